// File: hall_cond_core.sv
// field-sensor conditioning core: nonvolatile configuration store with shadows,
// write-protect latch, filter, gain, offset, limits and readout.
// assumes samples and decoded programming commands arrive on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "hall_cond_regs.svh"
module hall_cond_core #(
  parameter int PWM_PERIOD_CYCLES = `PWM_PERIOD_CYC
) (
  input wire logic clk, // core clock, 100 MHz
  input wire logic reset, // power-on reset, async, active high
  input wire logic signed [13:0] sample_in, // converter sample
  input wire logic sample_valid, // sample strobe
  input wire logic prog_valid, // decoded programming command
  input wire logic prog_write, // 1 write, 0 read
  input wire logic [3:0] prog_addr, // configuration word offset
  input wire logic [15:0] prog_wdata, // write data
  output logic [15:0] prog_rdata_ff, // read data
  output logic prog_rvalid_ff, // read answer strobe
  output hall_cond_pkg::field_range_t range_sel, // converter range
  output logic filter_1k, // filter corner is 1 kHz
  output hall_cond_pkg::out_format_t out_format, // selected output format
  output logic [1:0] drift_band, // drift band code
  output logic signed [12:0] drift_lo_ppm, // band lower bound
  output logic signed [12:0] drift_hi_ppm, // band upper bound
  output logic [4:0] drift_lin, // linear drift coefficient
  output logic [2:0] drift_quad, // quadratic drift coefficient
  output logic [13:0] readout_ff, // processed field value
  output logic [11:0] dac_code_ff, // voltage converter code
  output logic pwm_out_ff, // pulse-width output
  output logic locked // protect latch effective
);
  import hall_cond_pkg::*;

  // ************************************************************
  // store, shadows and protect latch
  // ************************************************************
  // the store has no reset: it keeps its contents across power cycles
  // an erased store reads as zero, so a fresh part comes up unlocked and programmable
  logic [15:0] nv_ff [`NUM_CFG_WORDS] = '{default: `CFG_RESET};
  logic [15:0] nxt_nv_ff [`NUM_CFG_WORDS];
  logic [15:0] cfg_ff [`NUM_CFG_WORDS];
  logic [15:0] nxt_cfg_ff [`NUM_CFG_WORDS];
  cfg_state_t state_ff, nxt_state_ff;
  logic [15:0] nxt_prog_rdata_ff;
  logic nxt_prog_rvalid_ff;
  logic accept;

  // communication is dropped entirely once the latch is effective
  assign accept = prog_valid && (state_ff == ST_RUN);

  always_comb begin
    nxt_nv_ff = nv_ff;
    if (accept && prog_write && prog_addr < 4'(`ADDR_READOUT)) begin
      nxt_nv_ff[prog_addr] = prog_wdata;
    end
  end

  always_ff @(posedge clk) begin
    nv_ff <= nxt_nv_ff;
  end

  always_comb begin
    nxt_state_ff = state_ff;
    nxt_cfg_ff = cfg_ff;
    case (state_ff)
      ST_LOAD: begin
        nxt_cfg_ff = nv_ff;
        // the latch is sampled only here, so setting it waits for a power cycle
        nxt_state_ff = nv_ff[`ADDR_LOCK][0] ? ST_LOCKED : ST_RUN;
      end
      ST_RUN: begin
        if (accept && prog_write && prog_addr < 4'(`ADDR_READOUT)) begin
          nxt_cfg_ff[prog_addr] = prog_wdata;
        end
      end
      ST_LOCKED: begin
        nxt_state_ff = ST_LOCKED;
      end
      default: begin
        nxt_state_ff = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_LOAD;
      for (int i = 0; i < `NUM_CFG_WORDS; i++) begin
        cfg_ff[i] <= `CFG_RESET;
      end
    end else begin
      state_ff <= nxt_state_ff;
      cfg_ff <= nxt_cfg_ff;
    end
  end

  assign locked = (state_ff == ST_LOCKED);

  // ************************************************************
  // read answers
  // ************************************************************
  always_comb begin
    nxt_prog_rvalid_ff = accept && !prog_write;
    nxt_prog_rdata_ff = prog_rdata_ff;
    if (accept && !prog_write) begin
      if (prog_addr == `ADDR_READOUT) begin
        nxt_prog_rdata_ff = {2'b00, readout_ff};
      end else if (prog_addr < 4'(`ADDR_READOUT)) begin
        nxt_prog_rdata_ff = cfg_ff[prog_addr];
      end else begin
        nxt_prog_rdata_ff = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_rdata_ff <= 16'h0000;
      prog_rvalid_ff <= 1'b0;
    end else begin
      prog_rdata_ff <= nxt_prog_rdata_ff;
      prog_rvalid_ff <= nxt_prog_rvalid_ff;
    end
  end

  // ************************************************************
  // mode decode with fallback for unlisted codes
  // ************************************************************
  logic [9:0] mode;
  logic [1:0] rng_code;
  logic [2:0] fmt_code;
  assign mode = cfg_ff[`ADDR_MODE][`MODE_W-1:0];
  assign rng_code = mode[`MODE_RANGE_HI:`MODE_RANGE_LO];
  assign fmt_code = mode[`MODE_FMT_HI:`MODE_FMT_LO];
  // codes 00 and 01 have no corner defined; the nearer 500 Hz is used
  assign filter_1k = (mode[`MODE_FILT_HI:`MODE_FILT_LO] == 2'b11);
  // any format code with the top bit set is nearer pulse width than voltage
  assign out_format = (fmt_code == 3'b110 || fmt_code[2]) ? FMT_PWM : FMT_VOLTAGE;

  always_comb begin
    if (mode[`MODE_RANGE_TOP]) begin
      range_sel = RNG_150;
    end else begin
      case (rng_code)
        2'b00: range_sel = RNG_30;
        2'b01: range_sel = RNG_60;
        2'b10: range_sel = RNG_80;
        default: range_sel = RNG_100;
      endcase
    end
  end

  // ************************************************************
  // drift compensation settings
  // ************************************************************
  assign drift_band = cfg_ff[`ADDR_BAND][`BAND_W-1:0];
  assign drift_lin = cfg_ff[`ADDR_LIN][`LIN_W-1:0];
  assign drift_quad = cfg_ff[`ADDR_QUAD][`QUAD_W-1:0];

  always_comb begin
    case (drift_band)
      2'd0: begin
        drift_lo_ppm = -13'sd3100;
        drift_hi_ppm = -13'sd2000;
      end
      2'd2: begin
        drift_lo_ppm = -13'sd1950;
        drift_hi_ppm = -13'sd550;
      end
      2'd1: begin
        drift_lo_ppm = -13'sd500;
        drift_hi_ppm = 13'sd450;
      end
      default: begin
        drift_lo_ppm = 13'sd450;
        drift_hi_ppm = 13'sd1000;
      end
    endcase
  end

  // ************************************************************
  // processing chain: filter, gain, offset, limits
  // ************************************************************
  logic signed [19:0] filt_ff, nxt_filt_ff;
  logic signed [19:0] step;
  logic signed [15:0] gain;
  logic signed [35:0] product;
  logic signed [19:0] scaled, summed;
  logic signed [19:0] lim_lo, lim_hi;
  logic [13:0] nxt_readout_ff;

  assign gain = cfg_ff[`ADDR_GAIN];
  assign step = {{6{sample_in[13]}}, sample_in} - filt_ff;

  always_comb begin
    nxt_filt_ff = filt_ff;
    if (sample_valid && state_ff != ST_LOAD) begin
      nxt_filt_ff = filt_ff + (filter_1k ? (step >>> `FILT_SHIFT_1K) : (step >>> `FILT_SHIFT_500));
    end
  end

  // gain is signed with 13 fraction bits, so the full word spans -4 to +4
  assign product = filt_ff * gain;
  assign scaled = product[`GAIN_FRAC+19:`GAIN_FRAC];
  assign summed = scaled + 20'(cfg_ff[`ADDR_OFFSET][`OFFSET_W-1:0]) * 20'sd16;
  assign lim_lo = 20'(cfg_ff[`ADDR_CLAMP_LO][`CLAMP_W-1:0]) <<< `CLAMP_SHIFT;
  assign lim_hi = `HALF_SCALE - 20'sd1 + ((20'(cfg_ff[`ADDR_CLAMP_HI][`CLAMP_W-1:0]) + 20'sd1) <<< `CLAMP_SHIFT);

  always_comb begin
    if (summed < lim_lo) begin
      nxt_readout_ff = lim_lo[13:0];
    end else if (summed > lim_hi) begin
      nxt_readout_ff = lim_hi[13:0];
    end else begin
      nxt_readout_ff = summed[13:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      filt_ff <= 20'sh00000;
      readout_ff <= 14'h0000;
    end else begin
      filt_ff <= nxt_filt_ff;
      readout_ff <= nxt_readout_ff;
    end
  end

  hall_out_stage #(
    .PERIOD_CYCLES(PWM_PERIOD_CYCLES)
  ) u_out (
    .clk(clk),
    .reset(reset),
    .value(readout_ff),
    .fmt(out_format),
    .dac_code_ff(dac_code_ff),
    .pwm_out_ff(pwm_out_ff)
  );

  // ************************************************************
  // checks
  // ************************************************************
  chk_load_one_cycle: assert property (@(posedge clk) disable iff (reset)
    state_ff == ST_LOAD |=> state_ff != ST_LOAD) else $error("store load did not finish");
  chk_lock_defers: assert property (@(posedge clk) disable iff (reset)
    state_ff == ST_RUN |=> state_ff == ST_RUN) else $error("latch took effect without power cycle");
  chk_locked_freeze: assert property (@(posedge clk) disable iff (reset)
    locked |=> $stable(cfg_ff[`ADDR_GAIN]) && $stable(cfg_ff[`ADDR_MODE]))
    else $error("config moved while locked");
  chk_locked_silent: assert property (@(posedge clk) disable iff (reset)
    locked ##1 prog_valid |=> !prog_rvalid_ff) else $error("answered while locked");
  chk_read_answer: assert property (@(posedge clk) disable iff (reset)
    state_ff == ST_RUN && prog_valid && !prog_write |=> prog_rvalid_ff)
    else $error("read not answered");
  chk_readout_low: assert property (@(posedge clk) disable iff (reset)
    state_ff == ST_RUN ##1 state_ff == ST_RUN |-> 20'(readout_ff) >= $past(lim_lo)) else $error("below lower limit");
  chk_readout_high: assert property (@(posedge clk) disable iff (reset)
    state_ff == ST_RUN ##1 state_ff == ST_RUN |-> 20'(readout_ff) <= $past(lim_hi)) else $error("above upper limit");
  chk_range_top: assert property (@(posedge clk) disable iff (reset)
    mode[`MODE_RANGE_TOP] |-> range_sel == RNG_150) else $error("wide range not selected");
  chk_filter_fallback: assert property (@(posedge clk) disable iff (reset)
    !mode[`MODE_FILT_HI] |-> !filter_1k) else $error("unlisted filter code not 500 Hz");

  // ************************************************************
  // decode, store and readout checks
  // ************************************************************
  // these pin the listed codes and the store path, which the bench reaches only indirectly
  chk_write_lands: assert property (@(posedge clk) disable iff (reset)
    accept && prog_write && prog_addr == `ADDR_GAIN |=> gain == $past(prog_wdata))
    else $error("gain write did not land");
  chk_load_copies: assert property (@(posedge clk) disable iff (reset)
    state_ff == ST_LOAD |=> cfg_ff[`ADDR_MODE] == $past(nv_ff[`ADDR_MODE]))
    else $error("shadow not loaded from store");
  chk_store_frozen: assert property (@(posedge clk) disable iff (reset)
    locked |=> $stable(nv_ff[`ADDR_GAIN]) && $stable(nv_ff[`ADDR_LOCK]))
    else $error("store moved while locked");
  chk_locked_refuse: assert property (@(posedge clk) disable iff (reset)
    locked && prog_valid |=> !prog_rvalid_ff)
    else $error("command answered while locked");
  chk_readout_word: assert property (@(posedge clk) disable iff (reset)
    accept && !prog_write && prog_addr == `ADDR_READOUT |=> prog_rdata_ff == {2'b00, $past(readout_ff)})
    else $error("readout word wrong");
  chk_filter_hold: assert property (@(posedge clk) disable iff (reset)
    !sample_valid |=> filt_ff == $past(filt_ff))
    else $error("filter moved without a sample");
  chk_format_voltage: assert property (@(posedge clk) disable iff (reset)
    fmt_code == 3'b000 |-> out_format == FMT_VOLTAGE)
    else $error("voltage format not selected");
  chk_format_pwm: assert property (@(posedge clk) disable iff (reset)
    fmt_code == 3'b110 |-> out_format == FMT_PWM)
    else $error("pulse width format not selected");
  chk_filter_fast: assert property (@(posedge clk) disable iff (reset)
    mode[`MODE_FILT_HI:`MODE_FILT_LO] == 2'b11 |-> filter_1k)
    else $error("1 kHz corner not selected");
  chk_range_narrow: assert property (@(posedge clk) disable iff (reset)
    !mode[`MODE_RANGE_TOP] && rng_code == 2'b00 |-> range_sel == RNG_30)
    else $error("narrow range not selected");
  chk_band_lowest: assert property (@(posedge clk) disable iff (reset)
    drift_band == 2'd0 |-> drift_lo_ppm == -13'sd3100 && drift_hi_ppm == -13'sd2000)
    else $error("band 0 bounds wrong");
  chk_band_highest: assert property (@(posedge clk) disable iff (reset)
    drift_band == 2'd3 |-> drift_lo_ppm == 13'sd450 && drift_hi_ppm == 13'sd1000)
    else $error("band 3 bounds wrong");
endmodule
`default_nettype wire

// File: hall_cond_pkg.sv
// types shared by the conditioning core and its output stage.
// assumes the constants header is included by the design files.
package hall_cond_pkg;
  typedef enum logic [2:0] {RNG_30, RNG_60, RNG_80, RNG_100, RNG_150} field_range_t;
  typedef enum logic {FMT_VOLTAGE, FMT_PWM} out_format_t;
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_LOCKED} cfg_state_t;
endpackage

// File: hall_cond_regs.svh
// constants for the field-sensor conditioning core: configuration word offsets,
// field positions, reset values and timing counts. assumes a 100 MHz core clock.
//
// Behaviour
// - field range from top mode bit and two-bit field; 1/11 gives 150mT.
// - filter corner field: code 10 gives 500 Hz, code 11 gives 1 kHz.
// - output format field: 000 selects voltage output, 110 selects pulse width.
// - voltage format drives a 12-bit converter code, ratiometric to the supply.
// - pulse-width format: 11-bit duty, 8 ms period, duty carries the value.
// - drift band code maps to its ppm/K span: 0, 2, 1, 3 ascending.
// - linear drift coefficient is 5 bits, quadratic 3 bits, within the band.
// - gain is a signed factor from -4 to +4 in fine steps.
// - zero-field offset is added; one step equals 4.9 mV.
// - output never below lower limit, 0 to half supply, 9.77 mV steps.
// - output never above upper limit, half to full supply, 9.77 mV steps.
// - four user storage words, no effect on processing.
// - active protect latch freezes configuration and ignores communication.
// - protect latch only takes effect after the next power cycle.
// - readable 14-bit processed value after the whole chain.
// - with latch active, neither programming nor readout commands are answered.
// - each filtered sample is multiplied by gain, offset added, then limited.
// - processed readout spans 0 to 16383.
`ifndef HALL_COND_REGS_SVH
`define HALL_COND_REGS_SVH

// configuration word offsets on the command port
`define ADDR_MODE       4'h0
`define ADDR_BAND       4'h1
`define ADDR_LIN        4'h2
`define ADDR_QUAD       4'h3
`define ADDR_GAIN       4'h4
`define ADDR_OFFSET     4'h5
`define ADDR_CLAMP_LO   4'h6
`define ADDR_CLAMP_HI   4'h7
`define ADDR_USER0      4'h8
`define ADDR_LOCK       4'hc
`define ADDR_READOUT    4'hd
`define NUM_CFG_WORDS   13

// mode word field positions
`define MODE_RANGE_TOP  9
`define MODE_FMT_HI     7
`define MODE_FMT_LO     5
`define MODE_FILT_HI    4
`define MODE_FILT_LO    3
`define MODE_RANGE_HI   2
`define MODE_RANGE_LO   1

// widths of the stored fields
`define MODE_W          10
`define BAND_W          2
`define LIN_W           5
`define QUAD_W          3
`define OFFSET_W        10
`define CLAMP_W         8

// reset value of every shadow before the store is copied in
`define CFG_RESET       16'h0000

// scaling of processing quantities, in readout counts
`define READOUT_MAX     14'h3fff
`define HALF_SCALE      20'sh02000
`define OFFSET_SHIFT    4
`define CLAMP_SHIFT     5
`define GAIN_FRAC       13
`define FILT_SHIFT_1K   3
`define FILT_SHIFT_500  4

// pulse-width timing
`define CLK_FREQ_MHZ    100
`define PWM_PERIOD_US   8000
`define PWM_PERIOD_CYC  (`PWM_PERIOD_US * `CLK_FREQ_MHZ)
`define PWM_SLOTS       2048

`endif

// File: hall_dsp_config_conditioning_bench.sv
// self-checking bench for the conditioning core driven by the programmer model.
// assumes a 100 MHz clock and a shortened pulse-width period.
`timescale 1ns/1ps
`default_nettype none
module hall_dsp_config_conditioning_bench;
  import hall_cond_pkg::*;
  localparam int PER = 4096;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic signed [13:0] sample_in = 14'sh0000;
  logic sample_valid = 1'b0;
  wire logic prog_valid, prog_write, prog_rvalid_ff, filter_1k, pwm_out_ff, locked;
  wire logic [3:0] prog_addr;
  wire logic [15:0] prog_wdata, prog_rdata_ff;
  wire field_range_t range_sel;
  wire out_format_t out_format;
  wire logic [1:0] drift_band;
  wire logic signed [12:0] drift_lo_ppm, drift_hi_ppm;
  wire logic [4:0] drift_lin;
  wire logic [2:0] drift_quad;
  wire logic [13:0] readout_ff;
  wire logic [11:0] dac_code_ff;
  int miscompares = 0, n_compared = 0, cycles = 0;
  int i, off, lo, hi, n, cnt, r1, r2;
  logic [15:0] rd, g;
  logic ok;
  logic [15:0] user_w [4];
  int mt [12][4] = '{'{'h000, 0, 0, 0}, '{'h002, 1, 0, 0}, '{'h004, 2, 0, 0}, '{'h006, 3, 0, 0},
    '{'h206, 4, 0, 0}, '{'h200, 4, 0, 0}, '{'h010, 0, 0, 0}, '{'h018, 0, 1, 0}, '{'h008, 0, 0, 0},
    '{'h0c0, 0, 0, 1}, '{'h020, 0, 0, 0}, '{'h0e0, 0, 0, 1}};
  int bt [4][2] = '{'{-3100, -2000}, '{-500, 450}, '{-1950, -550}, '{450, 1000}};
  always #5 clk = ~clk;
  hall_cond_core #(.PWM_PERIOD_CYCLES(PER)) i_hall_cond_core (.clk(clk), .reset(reset),
    .sample_in(sample_in), .sample_valid(sample_valid), .prog_valid(prog_valid),
    .prog_write(prog_write), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_rdata_ff(prog_rdata_ff), .prog_rvalid_ff(prog_rvalid_ff), .range_sel(range_sel),
    .filter_1k(filter_1k), .out_format(out_format), .drift_band(drift_band),
    .drift_lo_ppm(drift_lo_ppm), .drift_hi_ppm(drift_hi_ppm), .drift_lin(drift_lin),
    .drift_quad(drift_quad), .readout_ff(readout_ff), .dac_code_ff(dac_code_ff),
    .pwm_out_ff(pwm_out_ff), .locked(locked));
  hall_programmer i_hall_programmer (.clk(clk), .prog_valid(prog_valid), .prog_write(prog_write),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata_ff(prog_rdata_ff),
    .prog_rvalid_ff(prog_rvalid_ff));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_hall_programmer.cmd(1'b1, a, d);
  endtask
  task automatic power_cycle;
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc(3);
  endtask
  function automatic int exp_ro(input int o, input int l, input int h);
    int v;
    v = o * 16;
    if (v < l * 32) v = l * 32;
    if (v > 8191 + (h + 1) * 32) v = 8191 + (h + 1) * 32;
    return v;
  endfunction
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(49642));
    cyc(12);
    reset = 1'b0;
    cyc(3);
    for (i = 0; i < 4; i++) user_w[i] = 16'($urandom);
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0001);
    wr(4'h2, 16'h000f);
    wr(4'h3, 16'h0001);
    wr(4'h4, 16'h0000);
    wr(4'h5, 16'h0200);
    wr(4'h6, 16'h0000);
    wr(4'h7, 16'h00ff);
    for (i = 0; i < 4; i++) wr(4'(8 + i), user_w[i]);
    wr(4'hc, 16'h0000);
    power_cycle();
    for (i = 0; i < 4; i++) begin
      i_hall_programmer.rd(4'(8 + i), rd, ok);
      check("user word", {ok, rd}, {1'b1, user_w[i]});
    end
    check("linear coef", 32'(drift_lin), 32'd15);
    check("quad coef", 32'(drift_quad), 32'd1);
    i_hall_programmer.rd(4'he, rd, ok);
    check("reserved read", {ok, rd}, {1'b1, 16'h0000});
    for (i = 0; i < 12; i++) begin
      wr(4'h0, 16'(mt[i][0]));
      cyc(2);
      check("range", 32'(range_sel), mt[i][1]);
      check("filter", 32'(filter_1k), mt[i][2]);
      check("format", 32'(out_format), mt[i][3]);
    end
    for (i = 0; i < 4; i++) begin
      wr(4'h1, 16'(i));
      cyc(2);
      check("band code", 32'(drift_band), 32'(i));
      check("band low", 32'(drift_lo_ppm), bt[i][0]);
      check("band high", 32'(drift_hi_ppm), bt[i][1]);
    end
    wr(4'h0, 16'h0000);
    for (i = 0; i < 16; i++) begin
      off = (i == 0) ? 1023 : (i == 1) ? 0 : $urandom_range(1023);
      lo = (i < 2) ? 0 : $urandom_range(255);
      hi = (i == 0) ? 255 : $urandom_range(255);
      // zero gain: random samples must not reach the readout
      sample_in = 14'($urandom);
      sample_valid = 1'($urandom_range(1));
      wr(4'h5, 16'(off));
      wr(4'h6, 16'(lo));
      wr(4'h7, 16'(hi));
      cyc(5);
      check("readout", 32'(readout_ff), exp_ro(off, lo, hi));
      check("dac code", 32'(dac_code_ff), exp_ro(off, lo, hi) >> 2);
      check("pwm idle", 32'(pwm_out_ff), 32'd0);
      i_hall_programmer.rd(4'hd, rd, ok);
      check("readout word", {ok, rd}, {1'b1, 16'(exp_ro(off, lo, hi))});
    end
    wr(4'h5, 16'h0200);
    wr(4'h6, 16'h0000);
    wr(4'h7, 16'h00ff);
    sample_in = 14'sh03e8;
    sample_valid = 1'b1;
    wr(4'h4, 16'h2000);
    cyc(300);
    r1 = int'(readout_ff) - 9192;
    check("gain plus", 32'(r1 > -20 && r1 < 20), 32'd1);
    wr(4'h4, 16'he000);
    cyc(10);
    r1 = int'(readout_ff) - 7192;
    check("gain minus", 32'(r1 > -20 && r1 < 20), 32'd1);
    wr(4'h4, 16'h0000);
    off = 100 + $urandom_range(800);
    wr(4'h5, 16'(off));
    wr(4'h0, 16'h00c0);
    cyc(PER + 200);
    check("dac in pwm", 32'(dac_code_ff), 32'd0);
    n = 0;
    while (pwm_out_ff !== 1'b0 && n < PER) begin
      cyc(1);
      n++;
    end
    while (pwm_out_ff !== 1'b1 && n < 2 * PER) begin
      cyc(1);
      n++;
    end
    cnt = 0;
    for (i = 0; i < PER; i++) begin
      if (pwm_out_ff === 1'b1) cnt++;
      cyc(1);
    end
    check("pwm high time", 32'(cnt), 32'(off * 4));
    wr(4'h0, 16'h0010);
    i_hall_programmer.init_dsp(1'b0);
    sample_in = 14'sh0bb8;
    cyc(300);
    i_hall_programmer.rd(4'hd, rd, ok);
    r1 = int'(rd);
    sample_in = -14'sh0bb8;
    cyc(300);
    i_hall_programmer.rd(4'hd, rd, ok);
    r2 = int'(rd);
    g = i_hall_programmer.sens_code(4000, r1 - r2);
    i_hall_programmer.commit(g, 16'h0200);
    i_hall_programmer.rd(4'h4, rd, ok);
    check("gain word", {ok, rd}, {1'b1, g});
    i_hall_programmer.rd(4'hc, rd, ok);
    check("latch set", {ok, rd[0], locked}, 3'b110);
    power_cycle();
    check("locked", 32'(locked), 32'd1);
    i_hall_programmer.rd(4'h4, rd, ok);
    check("locked read", 32'(ok), 32'd0);
    wr(4'h0, 16'h0206);
    cyc(2);
    check("frozen range", 32'(range_sel), 32'(RNG_30));
    end_of_test();
  end
endmodule
`default_nettype wire

// File: hall_out_stage.sv
// output stage: converter code for voltage format and pulse-width generator.
// assumes the processed value arrives from flip-flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "hall_cond_regs.svh"
module hall_out_stage #(
  parameter int PERIOD_CYCLES = `PWM_PERIOD_CYC
) (
  input wire logic clk, // core clock
  input wire logic reset, // async, active high
  input wire logic [13:0] value, // processed field value
  input wire hall_cond_pkg::out_format_t fmt, // selected format
  output logic [11:0] dac_code_ff, // voltage converter code
  output logic pwm_out_ff // pulse-width output
);
  import hall_cond_pkg::*;

  // slots take equal whole cycles; leftover cycles form a low tail so the period stays exact
  localparam int SLOT_CYC = (PERIOD_CYCLES / `PWM_SLOTS) < 1 ? 1 : PERIOD_CYCLES / `PWM_SLOTS;
  localparam logic [19:0] SLOT_LAST = 20'(SLOT_CYC - 1);
  localparam logic [19:0] PERIOD_LAST = 20'(PERIOD_CYCLES - 1);

  logic [19:0] per_ff, nxt_per_ff;
  logic [19:0] pre_ff, nxt_pre_ff;
  logic [10:0] slot_ff, nxt_slot_ff;
  logic [10:0] duty_ff, nxt_duty_ff;
  logic [11:0] nxt_dac_code_ff;
  logic nxt_pwm_out_ff;

  always_comb begin
    nxt_dac_code_ff = (fmt == FMT_VOLTAGE) ? value[13:2] : 12'h000;
    nxt_per_ff = (per_ff == PERIOD_LAST) ? 20'h00000 : per_ff + 20'h00001;
    nxt_pre_ff = (pre_ff == SLOT_LAST || per_ff == PERIOD_LAST) ? 20'h00000 : pre_ff + 20'h00001;
    nxt_slot_ff = slot_ff;
    if (per_ff == PERIOD_LAST) begin
      nxt_slot_ff = 11'h000;
    end else if (pre_ff == SLOT_LAST && slot_ff != 11'h7ff) begin
      // the last slot stretches over the tail, where the output is always low
      nxt_slot_ff = slot_ff + 11'h001;
    end
    // duty is only taken at the period start so a period is never torn
    nxt_duty_ff = (per_ff == 20'h00000) ? value[13:3] : duty_ff;
    nxt_pwm_out_ff = (fmt == FMT_PWM) && (slot_ff < duty_ff);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dac_code_ff <= 12'h000;
      per_ff <= 20'h00000;
      pre_ff <= 20'h00000;
      slot_ff <= 11'h000;
      duty_ff <= 11'h000;
      pwm_out_ff <= 1'b0;
    end else begin
      dac_code_ff <= nxt_dac_code_ff;
      per_ff <= nxt_per_ff;
      pre_ff <= nxt_pre_ff;
      slot_ff <= nxt_slot_ff;
      duty_ff <= nxt_duty_ff;
      pwm_out_ff <= nxt_pwm_out_ff;
    end
  end

  chk_pwm_idle_voltage: assert property (@(posedge clk) disable iff (reset)
    fmt == FMT_VOLTAGE |=> !pwm_out_ff) else $error("pwm active in voltage format");
  chk_dac_tracks_value: assert property (@(posedge clk) disable iff (reset)
    fmt == FMT_VOLTAGE |=> dac_code_ff == $past(value[13:2])) else $error("dac code lags value");
endmodule
`default_nettype wire

// File: hall_programmer.sv
// calibration programmer model on the decoded command port of the core.
// assumes the core answers a read with a one-cycle strobe one edge later.
`timescale 1ns/1ps
`default_nettype none
module hall_programmer (
  input wire logic clk, // core clock
  output logic prog_valid, // command strobe
  output logic prog_write, // 1 write, 0 read
  output logic [3:0] prog_addr, // word offset
  output logic [15:0] prog_wdata, // write data
  input wire logic [15:0] prog_rdata_ff, // read data
  input wire logic prog_rvalid_ff // read answer
);
  initial begin
    prog_valid = 1'b0;
    prog_write = 1'b0;
    prog_addr = 4'h0;
    prog_wdata = 16'h0000;
  end
  // ****************************************
  // command cycles
  // ****************************************
  task automatic cmd(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    prog_valid = 1'b1;
    prog_write = wr;
    prog_addr = a;
    prog_wdata = d;
    @(posedge clk);
    #1;
    prog_valid = 1'b0;
    // released data must not keep showing the last word
    prog_wdata = ~d;
    prog_addr = ~a;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    cmd(1'b0, a, 16'h0000);
    // a slow answer is tolerated for a few cycles
    repeat (3) begin
      if (prog_rvalid_ff === 1'b1 && !ok) begin
        ok = 1'b1;
        d = prog_rdata_ff;
      end
      @(posedge clk);
      #1;
    end
  endtask
  task automatic init_dsp(input logic f1k);
    cmd(1'b1, 4'h5, 16'h0200);
    cmd(1'b1, 4'h6, 16'h0000);
    cmd(1'b1, 4'h7, 16'h00ff);
    cmd(1'b1, 4'h4, f1k ? 16'h0a46 : 16'h099a);
  endtask
  // dv_mv above 3500 keeps the two targets far apart
  function automatic logic [15:0] sens_code(input int dv_mv, input int dr);
    return 16'((longint'(dv_mv) * 16384 * 8192) / (longint'(2) * dr * 5000));
  endfunction
  task automatic commit(input logic [15:0] g, input logic [15:0] off);
    cmd(1'b1, 4'h4, g);
    cmd(1'b1, 4'h5, off);
    cmd(1'b1, 4'hc, 16'h0001);
  endtask
endmodule
`default_nettype wire
